// [sfr_pkg.sv]
// package for the serial frame receiver: register offsets, fields, reset values
// assumes a 32-bit ahb-lite bus with word-aligned registers
package sfr_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] SFR_DATA_OFF = 8'h00;   // data register, read pops fifo
  localparam logic [7:0] SFR_STAT_OFF = 8'h04;   // status register
  localparam logic [7:0] SFR_CTRL_OFF = 8'h08;   // control register
  localparam logic [7:0] SFR_BAUD_OFF = 8'h0c;   // baud divisor register

  // ************************************************************
  // status fields
  // ************************************************************
  localparam int SFR_ST_PE = 2;  // parity error
  localparam int SFR_ST_OV = 3;  // overrun
  localparam int SFR_ST_FE = 4;  // frame error
  localparam int SFR_ST_RC = 7;  // receive complete
  localparam int SFR_ST_B8 = 8;  // received ninth bit

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int SFR_CT_EN = 0;  // receive enable
  localparam int SFR_CT_IE = 1;  // receive complete irq enable
  localparam int SFR_CT_PT = 2;  // parity type, 1 odd
  localparam int SFR_CT_PEN = 3; // parity enable
  localparam int SFR_CT_SB = 4;  // stop bit count select (ignored by receiver)
  localparam int SFR_CT_DS = 5;  // double speed select
  localparam int SFR_CT_SY = 6;  // synchronous mode
  localparam int SFR_CT_SZ = 8;  // character size field, 3 bits, 0..4 -> 5..9 bits

  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [31:0] SFR_CTRL_RST = 32'h0000_0300; // 8 data bits, disabled
  localparam logic [15:0] SFR_BAUD_RST = 16'h0000;
  localparam logic [3:0] SFR_SMP_NORM = 4'hf;  // last sample index, 16 per bit
  localparam logic [3:0] SFR_SMP_DBL = 4'h7;   // last sample index, 8 per bit
  localparam logic [3:0] SFR_CTR_NORM = 4'h8;  // centre votes 8,9,10
  localparam logic [3:0] SFR_CTR_DBL = 4'h4;   // centre votes 4,5,6
  localparam logic [3:0] SFR_DBITS_MIN = 4'h5; // fewest data bits
  localparam logic [1:0] SFR_FIFO_DEPTH = 2'h2;

  typedef enum logic [3:0] {
    SFR_IDLE = 4'b0001,
    SFR_START = 4'b0010,
    SFR_BITS = 4'b0100,
    SFR_STOP = 4'b1000
  } sfr_state_t;

endpackage

// [sfr_receiver.sv]
// serial frame receiver with ahb-lite register slave and two-entry receive fifo
// assumes one clock hclk; serial pin and external transfer clock are asynchronous
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module sfr_receiver
  import sfr_pkg::*;
(
  input wire logic hclk,            // bus clock 100 mhz
  input wire logic hresetn,         // async reset, active low
  input wire logic hsel,            // slave select
  input wire logic [31:0] haddr,    // byte address
  input wire logic [1:0] htrans,    // transfer type
  input wire logic hwrite,          // write when high
  input wire logic [2:0] hsize,     // transfer size
  input wire logic hready,          // bus ready in
  input wire logic [31:0] hwdata,   // write data
  output logic [31:0] hrdata,       // read data
  output logic hreadyout,           // always ready
  output logic hresp,               // always okay
  input wire logic serial_input_pin,        // receive pin, async
  input wire logic external_transfer_clock, // sync mode clock pin, async
  output logic pin_override,        // high while receiver owns the pin
  output logic rx_irq               // receive complete request
);

  // ************************************************************
  // bus slave
  // ************************************************************
  logic wr_pend_reg, rd_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] baud_reg;
  wire addr_ok = hsel && hready && htrans[1];
  wire is_wr = wr_pend_reg;
  wire wr_ctrl = is_wr && addr_reg == SFR_CTRL_OFF;
  wire wr_baud = is_wr && addr_reg == SFR_BAUD_OFF;
  // pop happens in the address phase so read data is captured the same edge
  wire rd_data = addr_ok && !hwrite && haddr[7:0] == SFR_DATA_OFF;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      addr_reg <= haddr[7:0];
    end
  end

  // registers: status writes are dropped entirely, error flags not writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= SFR_CTRL_RST;
      baud_reg <= SFR_BAUD_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= hwdata;
      if (wr_baud) baud_reg <= hwdata[15:0];
    end
  end

  wire en = ctrl_reg[SFR_CT_EN];
  wire dbl = ctrl_reg[SFR_CT_DS];
  wire sync_mode = ctrl_reg[SFR_CT_SY];
  wire par_en = ctrl_reg[SFR_CT_PEN];
  wire [2:0] size_sel = ctrl_reg[SFR_CT_SZ +: 3];
  wire [3:0] nbits = SFR_DBITS_MIN + {1'b0, size_sel};
  assign pin_override = en;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic rx_s1_reg, rx_s2_reg, ck_s1_reg, ck_s2_reg, ck_d_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_d_reg <= 1'b0;
    end else begin
      rx_s1_reg <= serial_input_pin;
      rx_s2_reg <= rx_s1_reg;
      ck_s1_reg <= external_transfer_clock;
      ck_s2_reg <= ck_s1_reg;
      ck_d_reg <= ck_s2_reg;
    end
  end
  // rising edge of the transfer clock after synchronising
  wire ck_rise = ck_s2_reg && !ck_d_reg;
  // receive line as seen by the receiver, idle high when released
  wire rxd = en ? rx_s2_reg : 1'b1;

  // ************************************************************
  // baud tick and sampling
  // ************************************************************
  logic [15:0] div_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_reg <= 16'h0000;
    else if (!en || div_reg == 16'h0000) div_reg <= baud_reg;
    else div_reg <= div_reg - 16'h0001;
  end
  // one tick per sample; sync mode takes one tick per rising transfer clock edge
  wire async_tick = en && div_reg == 16'h0000;
  wire bit_tick_sync = en && ck_rise;
  wire [3:0] last_smp = dbl ? SFR_SMP_DBL : SFR_SMP_NORM;
  wire [3:0] ctr_smp = dbl ? SFR_CTR_DBL : SFR_CTR_NORM;

  sfr_state_t state_reg, state_next;
  logic [3:0] smp_reg;
  logic [1:0] vote_reg;
  logic [3:0] bit_reg;
  logic [8:0] shift_reg;
  logic par_reg;
  logic held_reg; // completed frame waiting in held_data_reg
  logic [8:0] held_data_reg;
  logic held_fe_reg, held_pe_reg;

  // sample k of a bit is taken while smp_reg holds k-1, so the centre votes sit one lower
  wire [3:0] vote_lo = ctr_smp - 4'h1;
  wire [3:0] vote_hi = ctr_smp + 4'h1;
  // third vote is the live sample, so the decision needs no extra cycle
  wire [2:0] votes = {vote_reg, rxd};
  wire maj = (votes[0] & votes[1]) | (votes[0] & votes[2])
    | (votes[1] & votes[2]);
  wire vote_done = async_tick && smp_reg == vote_hi;
  wire bit_end = sync_mode ? bit_tick_sync : (async_tick && smp_reg == last_smp);
  wire bit_val = sync_mode ? rxd : maj;
  wire bit_ready = sync_mode ? bit_tick_sync : vote_done;
  wire has_par = par_en;
  wire [3:0] nframe = nbits + {3'h0, has_par};

  // frame state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SFR_IDLE: if (en && !rxd && (sync_mode ? bit_tick_sync : async_tick))
        state_next = sync_mode ? SFR_BITS : SFR_START;
      SFR_START: if (vote_done)
        state_next = maj ? SFR_IDLE : SFR_START;
        else if (bit_end) state_next = SFR_BITS;
      SFR_BITS: if (bit_ready && bit_reg == nframe - 4'h1) state_next = SFR_STOP;
      SFR_STOP: if (bit_ready) state_next = SFR_IDLE;
    endcase
    if (!en) state_next = SFR_IDLE;
  end

  // sample counter, votes and shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SFR_IDLE;
      smp_reg <= 4'h0;
      vote_reg <= 2'h3;
      bit_reg <= 4'h0;
      shift_reg <= 9'h000;
      par_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == SFR_IDLE) begin
        smp_reg <= 4'h1;
        bit_reg <= 4'h0;
        par_reg <= 1'b0;
        shift_reg <= 9'h000;
      end else if (async_tick) begin
        smp_reg <= (smp_reg == last_smp) ? 4'h0 : smp_reg + 4'h1;
        if (smp_reg >= vote_lo && smp_reg <= vote_hi)
          vote_reg <= {vote_reg[0], rxd};
      end
      if (state_reg == SFR_BITS && bit_ready) begin
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg < nbits) begin
          shift_reg[bit_reg] <= bit_val;
          par_reg <= par_reg ^ bit_val;
        end else begin
          par_reg <= par_reg ^ bit_val ^ ctrl_reg[SFR_CT_PT];
        end
      end
    end
  end

  wire frame_done = state_reg == SFR_STOP && bit_ready && en;
  wire start_seen = state_reg == SFR_IDLE && state_next != SFR_IDLE;

  // ************************************************************
  // receive fifo, two entries: data, ninth bit, fe, pe, ov
  // ************************************************************
  logic [11:0] fifo_mem [0:1];
  logic rp_reg, wp_reg;
  logic [1:0] cnt_reg;
  logic ov_reg;
  wire full = cnt_reg == SFR_FIFO_DEPTH;
  wire empty = cnt_reg == 2'h0;
  wire pop = rd_data && !empty;
  wire push = held_reg && (!full || pop);
  wire [11:0] head = fifo_mem[rp_reg];

  // completed frame parked until a fifo slot is free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_reg <= 1'b0;
      held_data_reg <= 9'h000;
      held_fe_reg <= 1'b0;
      held_pe_reg <= 1'b0;
    end else if (!en) begin
      held_reg <= 1'b0;
    end else if (frame_done) begin
      held_reg <= 1'b1;
      held_data_reg <= shift_reg;
      held_fe_reg <= !bit_val;
      held_pe_reg <= par_en && par_reg;
    end else if (push) begin
      held_reg <= 1'b0;
    end
  end

  // overrun: set on start with full fifo and a parked frame, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ov_reg <= 1'b0;
    else if (!en) ov_reg <= 1'b0;
    else if (start_seen && full && held_reg && !pop) ov_reg <= 1'b1;
    else if (push) ov_reg <= 1'b0;
  end

  // fifo pointers; flush on disable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rp_reg <= 1'b0;
      wp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (!en) begin
      rp_reg <= 1'b0;
      wp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (pop) rp_reg <= !rp_reg;
      if (push) wp_reg <= !wp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // entries carry their own flags; overrun tagged onto the frame that follows loss
  always_ff @(posedge hclk) begin
    if (push) fifo_mem[wp_reg] <= {ov_reg, held_pe_reg, held_fe_reg, held_data_reg};
  end

  // ************************************************************
  // read data and interrupt
  // ************************************************************
  logic [8:0] mask9;
  always_comb begin
    mask9 = 9'h000;
    for (int i = 0; i < 9; i++) mask9[i] = 4'(i) < nbits;
  end
  // gated by enable so a disable empties the view at once, ahead of the flush edge
  wire rc = en && !empty;
  wire [8:0] hd = rc ? (head[8:0] & mask9) : 9'h000;
  wire [31:0] stat_word = {23'h0, hd[8], rc, 2'h0, head[9] & rc,
    head[11] & rc, head[10] & rc & par_en, 2'h0};
  wire [31:0] rd_mux = (haddr[7:0] == SFR_DATA_OFF) ? {24'h0, hd[7:0]} :
    (haddr[7:0] == SFR_STAT_OFF) ? stat_word :
    (haddr[7:0] == SFR_CTRL_OFF) ? ctrl_reg :
    (haddr[7:0] == SFR_BAUD_OFF) ? {16'h0, baud_reg} : 32'h0;

  // capture read data at the address phase so pop and data agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0;
    else if (addr_ok && !hwrite) hrdata <= rd_mux;
  end

  // only receive complete drives the request
  assign rx_irq = rc && ctrl_reg[SFR_CT_IE];

  // ************************************************************
  // checks
  // ************************************************************
  property p_rc_empty;
    @(posedge hclk) disable iff (!hresetn) rc == (en && cnt_reg != 2'h0);
  endproperty
  a_rc_empty: assert property (p_rc_empty) else $error("rc not tied to fifo");

  property p_flush;
    @(posedge hclk) disable iff (!hresetn) $fell(en) |-> !rc;
  endproperty
  a_flush: assert property (p_flush) else $error("fifo not flushed");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn) rx_irq == (rc && ctrl_reg[SFR_CT_IE]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_pe_off;
    @(posedge hclk) disable iff (!hresetn) !par_en |-> !stat_word[SFR_ST_PE];
  endproperty
  a_pe_off: assert property (p_pe_off) else $error("parity flag while off");

  property p_abandon;
    @(posedge hclk) disable iff (!hresetn) !en |=> state_reg == SFR_IDLE;
  endproperty
  a_abandon: assert property (p_abandon) else $error("reception not abandoned");

  property p_ov_clr;
    @(posedge hclk) disable iff (!hresetn) push && !start_seen |=> !ov_reg;
  endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("overrun not cleared");

  property p_pop;
    @(posedge hclk) disable iff (!hresetn) en && pop && !push |=> cnt_reg == $past(cnt_reg) - 2'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not advance fifo");

  property p_no_disable_push;
    @(posedge hclk) disable iff (!hresetn) frame_done |=> held_reg;
  endproperty
  a_no_disable_push: assert property (p_no_disable_push) else $error("frame lost");

  property p_pin;
    @(posedge hclk) disable iff (!hresetn) pin_override == en;
  endproperty
  a_pin: assert property (p_pin) else $error("pin override wrong");

  property p_fe_store;
    @(posedge hclk) disable iff (!hresetn) frame_done |=> held_fe_reg == !$past(bit_val);
  endproperty
  a_fe_store: assert property (p_fe_store) else $error("frame error not stop inverse");

  property p_irq_rc;
    @(posedge hclk) disable iff (!hresetn) rx_irq |-> rc;
  endproperty
  a_irq_rc: assert property (p_irq_rc) else $error("irq without receive complete");

  property p_ov_set;
    @(posedge hclk) disable iff (!hresetn) start_seen && full && held_reg && !pop |=> ov_reg;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("overrun not flagged");

  property p_head_hold;
    @(posedge hclk) disable iff (!hresetn) en && !empty && !pop |=> !en || head == $past(head);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("head entry changed unread");

  property p_start_reject;
    @(posedge hclk) disable iff (!hresetn)
      state_reg == SFR_START && vote_done && maj |=> state_reg == SFR_IDLE;
  endproperty
  a_start_reject: assert property (p_start_reject) else $error("noise start kept");

  property p_sync_hold;
    @(posedge hclk) disable iff (!hresetn)
      en && sync_mode && !bit_tick_sync && state_reg == SFR_BITS |=> bit_reg == $past(bit_reg);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("bit taken without clock edge");

endmodule

// [sfr_remote_tx.sv]
// remote serial transmitter model driving the receive pin and transfer clock
// assumes hclk is the bench clock and a bit lasts a whole number of hclk cycles
`timescale 1ns/1ps
module sfr_remote_tx (
  input wire logic hclk, // bench clock
  output logic line,     // serial line, idle high
  output logic xclk      // transfer clock, still outside frames
);
  // ************************************************************
  // line idles high, clock idles low
  // ************************************************************
  initial begin
    line = 1'b1;
    xclk = 1'b0;
  end

  // ************************************************************
  // bit and frame tasks
  // ************************************************************
  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // rising clock edge mid-bit, so the line is long settled when sampled
  task automatic put_bit(input logic b, input int len, input logic sy);
    line <= b;
    if (sy) begin
      hold(len / 2);
      xclk <= 1'b1;
      hold(len - len / 2);
      xclk <= 1'b0;
    end else begin
      hold(len);
    end
  endtask

  // parity over data bits only, odd high means odd; flip corrupts it
  task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic odd,
    input logic flip, input logic stop_v, input int len, input logic sy);
    logic p;
    p = odd ^ flip;
    for (int i = 0; i < nb; i++) p = p ^ d[i];
    put_bit(1'b0, len, sy);
    for (int i = 0; i < nb; i++) put_bit(d[i], len, sy);
    if (pen) put_bit(p, len, sy);
    put_bit(stop_v, len, sy);
    line <= 1'b1;
    hold(2 * len);
  endtask

  // short low pulse, too short to survive the start vote
  task automatic glitch(input int n);
    line <= 1'b0;
    hold(n);
    line <= 1'b1;
    hold(48);
  endtask
endmodule

// [test_serial_frame_receiver.sv]
// self-checking bench for the serial frame receiver
// assumes sfr_pkg, sfr_receiver and sfr_remote_tx are compiled before it
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_serial_frame_receiver
  import sfr_pkg::*;
  ;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pin_override, rx_irq, line, xclk;
  logic [31:0] rd;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  localparam logic [6:0] EN = 7'(1 << SFR_CT_EN);
  localparam logic [6:0] IE = 7'(1 << SFR_CT_IE);
  localparam logic [6:0] PT = 7'(1 << SFR_CT_PT);
  localparam logic [6:0] PEN = 7'(1 << SFR_CT_PEN);
  localparam logic [6:0] DS = 7'(1 << SFR_CT_DS);
  localparam logic [6:0] SY = 7'(1 << SFR_CT_SY);

  // ************************************************************
  // clock, timeout, instances
  // ************************************************************
  always #5 hclk = ~hclk;

  // generous ceiling; the whole run needs well under a third of it
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      summarize();
    end
  end

  sfr_receiver sfr_receiver_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_input_pin(line),
    .external_transfer_clock(xclk), .pin_override(pin_override), .rx_irq(rx_irq));
  sfr_remote_tx sfr_remote_tx_i (.hclk(hclk), .line(line), .xclk(xclk));

  // ************************************************************
  // bus and check helpers
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic ctl(input logic [2:0] sz, input logic [6:0] f);
    bus(1'b1, SFR_CTRL_OFF, {21'h0, sz, 1'b0, f});
  endtask

  // expected order: ninth bit, complete, frame, overrun, parity
  task automatic st(input logic [4:0] exp);
    bus(1'b0, SFR_STAT_OFF, 32'h0);
    `CHK({rd[SFR_ST_B8], rd[SFR_ST_RC], rd[SFR_ST_FE], rd[SFR_ST_OV], rd[SFR_ST_PE]}, exp)
  endtask

  task automatic rdd(input logic [7:0] exp);
    bus(1'b0, SFR_DATA_OFF, 32'h0);
    `CHK(rd, {24'h0, exp})
  endtask

  task automatic tx8(input logic [8:0] d);
    sfr_remote_tx_i.send(d, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b0);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    `CHK({pin_override, rx_irq, hresp}, 3'b000)
    bus(1'b0, SFR_CTRL_OFF, 32'h0);
    `CHK(rd, SFR_CTRL_RST)
    bus(1'b1, SFR_BAUD_OFF, 32'h1);
    bus(1'b0, SFR_BAUD_OFF, 32'h0);
    `CHK(rd, 32'h1)
    bus(1'b1, SFR_BAUD_OFF, {16'h0, SFR_BAUD_RST});
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0)
    st(5'b00000);
    $display("test reset done");
  endtask

  task automatic t_basic();
    ctl(3'h3, EN | IE);
    tx8(9'h0a5);
    `CHK(pin_override, 1'b1)
    st(5'b01000);
    `CHK(rx_irq, 1'b1)
    rdd(8'ha5);
    st(5'b00000);
    `CHK(rx_irq, 1'b0)
    $display("test basic done");
  endtask

  // every size, double speed on odd sizes
  task automatic t_sizes();
    logic ds;
    for (int s = 0; s < 5; s++) begin
      ds = s[0];
      ctl(3'(s), EN | (ds ? DS : 7'h0));
      sfr_remote_tx_i.send(9'h15a, s + 5, 1'b0, 1'b0, 1'b0, 1'b1, ds ? 8 : 16, 1'b0);
      st({s == 4, 4'b1000});
      rdd(8'h5a & 8'((1 << (s + 5)) - 1));
    end
    $display("test sizes done");
  endtask

  task automatic t_err();
    ctl(3'h3, EN);
    sfr_remote_tx_i.send(9'h03c, 8, 1'b0, 1'b0, 1'b0, 1'b0, 16, 1'b0);
    tx8(9'h0c3);
    st(5'b01100);
    `CHK(rx_irq, 1'b0)
    bus(1'b1, SFR_STAT_OFF, 32'h0000_009c);
    st(5'b01100);
    rdd(8'h3c);
    st(5'b01000);
    rdd(8'hc3);
    $display("test errors done");
  endtask

  // both parity types, right and wrong parity bit
  task automatic t_parity();
    for (int k = 0; k < 4; k++) begin
      ctl(3'h3, EN | PEN | (k[0] ? PT : 7'h0));
      sfr_remote_tx_i.send(9'h06b, 8, 1'b1, k[0], k[1], 1'b1, 16, 1'b0);
      st({4'b0100, k[1]});
      if (k == 3) begin
        ctl(3'h3, EN);
        st(5'b01000);
      end
      rdd(8'h6b);
    end
    $display("test parity done");
  endtask

  // four frames unread: two queued, third parked, fourth start overruns and
  // the fourth replaces the parked third, so the loss lies before it
  task automatic t_overrun();
    ctl(3'h3, EN);
    for (int i = 1; i < 5; i++) tx8(9'(i * 17));
    st(5'b01000);
    rdd(8'h11);
    st(5'b01000);
    rdd(8'h22);
    st(5'b01010);
    rdd(8'h44);
    repeat (3) begin
      bus(1'b0, SFR_STAT_OFF, 32'h0);
      if (rd[SFR_ST_RC] === 1'b1) bus(1'b0, SFR_DATA_OFF, 32'h0);
    end
    st(5'b00000);
    tx8(9'h077);
    st(5'b01000);
    rdd(8'h77);
    $display("test overrun done");
  endtask

  task automatic t_disable();
    ctl(3'h3, EN | IE);
    tx8(9'h055);
    ctl(3'h3, IE);
    st(5'b00000);
    `CHK({pin_override, rx_irq}, 2'b00)
    ctl(3'h3, EN | IE);
    fork
      tx8(9'h099);
      begin
        repeat (60) @(posedge hclk);
        ctl(3'h3, IE);
      end
    join
    ctl(3'h3, EN | IE);
    st(5'b00000);
    tx8(9'h066);
    rdd(8'h66);
    $display("test disable done");
  endtask

  task automatic t_noise_sync();
    ctl(3'h3, EN);
    sfr_remote_tx_i.glitch(4);
    st(5'b00000);
    ctl(3'h3, EN | SY);
    sfr_remote_tx_i.send(9'h081, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b1);
    st(5'b01000);
    rdd(8'h81);
    $display("test noise and sync done");
  endtask

  // ************************************************************
  // verdict and main sequence
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_basic();
    t_sizes();
    t_err();
    t_parity();
    t_overrun();
    t_disable();
    t_noise_sync();
    summarize();
  end
endmodule
